// ==== core/frc_cell_clocking.sv ====
// register cells, clock networks, combinational cell and probe selection
//
// Register access over Wishbone and the address map were left to the implementer.
`timescale 1ns/10ps
module frc_cell_clocking
    import frc_pkg::*;
#(
    parameter int   NUM_CELLS     = 4,
    parameter logic TRST_RESERVED = 1'b0
)(
    // system
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST_B,
    // wishbone slave
    input  wire logic                   WB_CYC_I,
    input  wire logic                   WB_STB_I,
    input  wire logic                   WB_WE_I,
    input  wire logic [frc_pkg::ADR_W-1:0] WB_ADR_I,
    input  wire logic [3:0]             WB_SEL_I,
    input  wire logic [31:0]            WB_DAT_I,
    output logic      [31:0]            WB_DAT_O,
    output logic                        WB_ACK_O,
    // clock pins
    input  wire logic                   HARDWIRED_CLOCK,
    input  wire logic                   ROUTED_CLOCK_A,
    input  wire logic                   ROUTED_CLOCK_B,
    input  wire logic                   QUADRANT_CLOCK_BOTTOM_LEFT,
    input  wire logic                   QUADRANT_CLOCK_BOTTOM_RIGHT,
    input  wire logic                   QUADRANT_CLOCK_TOP_LEFT,
    input  wire logic                   QUADRANT_CLOCK_TOP_RIGHT,
    input  wire logic                   TEST_RESET_PIN,
    // register cell pins
    input  wire logic [NUM_CELLS-1:0]   CELL_CLEAR,
    input  wire logic [NUM_CELLS-1:0]   CELL_PRESET,
    output logic      [NUM_CELLS-1:0]   CELL_Q,
    // boundary scan and probes
    input  wire logic                   SCAN_TCK,
    input  wire logic                   SCAN_TMS,
    input  wire logic                   SCAN_TDI,
    output logic                        SCAN_TDO,
    output logic                        PROBE_OUT_A,
    output logic                        PROBE_OUT_B
);
    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (NUM_CELLS < 1 || NUM_CELLS > 4) begin : g_bad
        $error("NUM_CELLS must be 1 to 4");
    end

    localparam int PW  = 11 + 2 * NUM_CELLS;
    localparam int CLR = 11;
    localparam int PRE = 11 + NUM_CELLS;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    logic [PW-1:0] pin_raw;
    logic [PW-1:0] s1_r;
    logic [PW-1:0] s2_r;
    logic [PW-1:0] s3_r;

    assign pin_raw = {CELL_PRESET, CELL_CLEAR, TEST_RESET_PIN, SCAN_TDI, SCAN_TMS, SCAN_TCK,
                      QUADRANT_CLOCK_TOP_RIGHT, QUADRANT_CLOCK_TOP_LEFT,
                      QUADRANT_CLOCK_BOTTOM_RIGHT, QUADRANT_CLOCK_BOTTOM_LEFT,
                      ROUTED_CLOCK_B, ROUTED_CLOCK_A, HARDWIRED_CLOCK};

    // no reset: stages carry true pin levels right after reset, so no false hardwired or scan clock edges
    always_ff @(posedge SYS_CLK)
    begin
        s1_r <= pin_raw;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    logic [31:0] cfg_r;
    logic [31:0] ctl_r;
    logic [31:0] lut_r;
    logic [31:0] cin_r;
    logic [31:0] quad_r;
    logic [31:0] status;
    logic        ack_r;
    logic        bus_go;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] din,
                                          input logic [3:0] sel);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++)
        begin
            if (sel[b])
            begin
                res[8*b +: 8] = din[8*b +: 8];
            end
        end
        return res;
    endfunction

    assign bus_go = WB_CYC_I && WB_STB_I && !ack_r;

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            cfg_r  <= RST_REG;
            ctl_r  <= RST_REG;
            lut_r  <= RST_LUT;
            cin_r  <= RST_REG;
            quad_r <= RST_REG;
        end
        else if (bus_go && WB_WE_I)
        begin
            case (WB_ADR_I)
                ADR_CELL_CFG: cfg_r  <= merge(cfg_r, WB_DAT_I, WB_SEL_I);
                ADR_CELL_CTL: ctl_r  <= merge(ctl_r, WB_DAT_I, WB_SEL_I);
                ADR_LUT:      lut_r  <= merge(lut_r, WB_DAT_I, WB_SEL_I);
                ADR_CC_IN:    cin_r  <= merge(cin_r, WB_DAT_I, WB_SEL_I);
                ADR_QUAD:     quad_r <= merge(quad_r, WB_DAT_I, WB_SEL_I);
                default:      ;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            ack_r    <= 1'b0;
            WB_DAT_O <= '0;
        end
        else
        begin
            ack_r <= bus_go;
            if (bus_go && !WB_WE_I)
            begin
                case (WB_ADR_I)
                    ADR_CELL_CFG: WB_DAT_O <= cfg_r;
                    ADR_CELL_CTL: WB_DAT_O <= ctl_r;
                    ADR_LUT:      WB_DAT_O <= lut_r;
                    ADR_CC_IN:    WB_DAT_O <= cin_r;
                    ADR_QUAD:     WB_DAT_O <= quad_r;
                    ADR_STATUS:   WB_DAT_O <= status;
                    default:      WB_DAT_O <= '0;
                endcase
            end
        end
    end

    assign WB_ACK_O = ack_r;

    // ------------------------------------------------------------
    // combinational cell
    // ------------------------------------------------------------
    logic       cc_q_r;
    logic [4:0] cc_idx;

    // inputs come from software only, never from the hardwired clock
    assign cc_idx = {cin_r[CIN_INV_IN] ^ cin_r[CIN_INV_EN], cin_r[3:0]};

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            cc_q_r <= 1'b0;
        end
        else
        begin
            cc_q_r <= lut_r[cc_idx];
        end
    end

    // ------------------------------------------------------------
    // clock networks
    // ------------------------------------------------------------
    logic       ra_lvl;
    logic       rb_lvl;
    logic       ra_prev_r;
    logic       rb_prev_r;
    logic       cc_prev_r;
    logic [3:0] q_lvl;
    logic [3:0] q_prev_r;
    logic [1:0] hclk_cnt_r;
    logic [1:0] fill_r;
    logic       bypass_r;
    logic       hclk_open;

    assign ra_lvl = cfg_r[CFG_RA_INT] ? cc_q_r : s2_r[1];
    assign rb_lvl = cfg_r[CFG_RB_INT] ? cc_q_r : s2_r[2];

    for (genvar k = 0; k < 4; k++) begin : g_quad
        // each quadrant picks which quadrant pin drives it
        assign q_lvl[k] = s2_r[3 + 32'(quad_r[2*k +: 2])];
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            ra_prev_r <= 1'b0;
            rb_prev_r <= 1'b0;
            cc_prev_r <= 1'b0;
            q_prev_r  <= '0;
        end
        else
        begin
            ra_prev_r <= ra_lvl;
            rb_prev_r <= rb_lvl;
            cc_prev_r <= cc_q_r;
            q_prev_r  <= q_lvl;
        end
    end

    // hardwired clock startup gate, counted on falling edges
    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            hclk_cnt_r <= '0;
            fill_r     <= '0;
            bypass_r   <= 1'b0;
        end
        else
        begin
            if (s3_r[0] && !s2_r[0] && hclk_cnt_r != HCLK_HOLD)
            begin
                hclk_cnt_r <= hclk_cnt_r + 2'h1;
            end
            if (fill_r != SYNC_FILL)
            begin
                fill_r   <= fill_r + 2'h1;
                bypass_r <= TRST_RESERVED && !s2_r[10];
            end
        end
    end

    assign hclk_open = (hclk_cnt_r == HCLK_HOLD) || bypass_r;

    function automatic logic edge_of(input logic [2:0] src, input logic pol,
                                     input logic [4:0] lv, input logic [4:0] pv);
        int n;
        case (src)
            SRC_HARD: n = 0;
            SRC_RA:   n = 1;
            SRC_RB:   n = 2;
            SRC_INT:  n = 3;
            SRC_QUAD: n = 4;
            default:  n = 0;
        endcase
        return pol ? (pv[n] && !lv[n]) : (lv[n] && !pv[n]);
    endfunction

    // ------------------------------------------------------------
    // register cells
    // ------------------------------------------------------------
    logic [NUM_CELLS-1:0] q_r;
    logic [NUM_CELLS-1:0] cell_edge;
    logic [NUM_CELLS-1:0] cell_ce;
    logic [NUM_CELLS-1:0] cell_d;
    logic [NUM_CELLS-1:0] clr_s;
    logic [NUM_CELLS-1:0] pre_s;

    assign clr_s = s2_r[CLR +: NUM_CELLS];
    assign pre_s = s2_r[PRE +: NUM_CELLS];

    for (genvar i = 0; i < NUM_CELLS; i++) begin : g_cell
        logic [4:0] lv;
        logic [4:0] pv;
        logic [2:0] src;
        assign lv  = {q_lvl[i], cc_q_r, rb_lvl, ra_lvl, s2_r[0]};
        assign pv  = {q_prev_r[i], cc_prev_r, rb_prev_r, ra_prev_r, s3_r[0]};
        assign src = cfg_r[CFG_FW*i +: 3];
        // hardwired edges only count once the gate is open
        assign cell_edge[i] = edge_of(src, cfg_r[CFG_FW*i + CFG_POL], lv, pv)
                              && (src != SRC_HARD || hclk_open);
        assign cell_ce[i]   = ctl_r[CTL_FW*i + CTL_S0] || ctl_r[CTL_FW*i + CTL_S1];
        assign cell_d[i]    = ctl_r[CTL_FW*i + CTL_D];

        always_ff @(posedge SYS_CLK)
        begin
            if (!RST_B)
            begin
                q_r[i] <= 1'b0;
            end
            else if (clr_s[i])
            begin
                q_r[i] <= 1'b0;
            end
            else if (pre_s[i])
            begin
                q_r[i] <= 1'b1;
            end
            else if (cell_edge[i] && cell_ce[i])
            begin
                q_r[i] <= cell_d[i];
            end
        end
    end

    assign CELL_Q = q_r;

    // ------------------------------------------------------------
    // probe selection over the scan port
    // ------------------------------------------------------------
    frc_scan_t             scan_r;
    logic [SCAN_LEN-1:0]   shift_r;
    logic [SCAN_LEN-1:0]   psel_r;
    logic [15:0]           nets;
    logic                  tck_rise;
    logic                  pa_r;
    logic                  pb_r;

    assign tck_rise = s2_r[7] && !s3_r[7];
    assign nets = 16'({q_lvl, rb_lvl, ra_lvl, s2_r[0] && hclk_open, cc_q_r, q_r});

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            scan_r  <= SCAN_IDLE;
            shift_r <= '0;
            psel_r  <= '0;
        end
        else
        begin
            case (scan_r)
                SCAN_IDLE:
                begin
                    if (tck_rise && s2_r[8])
                    begin
                        shift_r <= {shift_r[SCAN_LEN-2:0], s2_r[9]};
                        scan_r  <= SCAN_SHIFT;
                    end
                end
                SCAN_SHIFT:
                begin
                    if (tck_rise && s2_r[8])
                    begin
                        shift_r <= {shift_r[SCAN_LEN-2:0], s2_r[9]};
                    end
                    else if (tck_rise)
                    begin
                        scan_r <= SCAN_LOAD;
                    end
                end
                SCAN_LOAD:
                begin
                    psel_r <= shift_r;
                    scan_r <= SCAN_IDLE;
                end
                default: scan_r <= SCAN_IDLE;
            endcase
        end
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (!RST_B)
        begin
            pa_r <= 1'b0;
            pb_r <= 1'b0;
        end
        else
        begin
            pa_r <= nets[psel_r[PSEL_W-1:0]];
            pb_r <= nets[psel_r[SCAN_LEN-1:PSEL_W]];
        end
    end

    assign PROBE_OUT_A = pa_r;
    assign PROBE_OUT_B = pb_r;
    assign SCAN_TDO    = shift_r[SCAN_LEN-1];
    assign status = 32'({psel_r, 2'h0, hclk_open, cc_q_r, 4'(q_r)});

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_B);

    AST_CLEAR: assert property (clr_s[0] |=> !q_r[0])
        else $error("clear did not force low");
    AST_CLR_WINS: assert property (clr_s[0] && pre_s[0] |=> !q_r[0])
        else $error("preset beat clear");
    AST_PRESET: assert property (pre_s[0] && !clr_s[0] |=> q_r[0])
        else $error("preset did not force high");
    AST_HOLD: assert property (!clr_s[0] && !pre_s[0] && !cell_ce[0] |=> $stable(q_r[0]))
        else $error("cell changed while disabled");
    AST_LOAD: assert property (!clr_s[0] && !pre_s[0] && cell_edge[0] && cell_ce[0]
                               |=> q_r[0] == $past(cell_d[0]))
        else $error("cell missed its load");
    AST_NOEDGE: assert property (!clr_s[0] && !pre_s[0] && !cell_edge[0]
                                 |=> $stable(q_r[0]))
        else $error("cell loaded without active edge");
    AST_HGATE: assert property (hclk_cnt_r != HCLK_HOLD && !bypass_r |-> !hclk_open)
        else $error("hardwired clock open too early");
    AST_BYPASS: assert property (bypass_r |-> hclk_open)
        else $error("grounded test reset did not open clock");
    AST_ROUTED: assert property (cfg_r[CFG_RA_INT] |-> ra_lvl == cc_q_r)
        else $error("routed clock ignored internal source");
    AST_CCELL: assert property ($past(RST_B) |-> cc_q_r == $past(lut_r[cc_idx]))
        else $error("combinational cell output wrong");
    AST_PROBE: assert property (scan_r == SCAN_LOAD ##1 1'b1 ##1 1'b1
                                |-> PROBE_OUT_A == $past(nets[psel_r[PSEL_W-1:0]]))
        else $error("probe output not selected net");
    AST_ACK: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");

    COV_HCLK_OPEN: cover property (!hclk_open ##1 hclk_open);
    COV_FALL_LOAD: cover property (cell_edge[0] && cell_ce[0] && cfg_r[CFG_POL]);
    COV_PROBE_LOAD: cover property (scan_r == SCAN_LOAD);
endmodule // frc_cell_clocking

// ==== core/frc_pkg.sv ====
// constants shared by the register cell and clock network block
package frc_pkg;
    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam int          ADR_W        = 8;
    localparam logic [7:0]  ADR_CELL_CFG = 8'h00;
    localparam logic [7:0]  ADR_CELL_CTL = 8'h04;
    localparam logic [7:0]  ADR_LUT      = 8'h08;
    localparam logic [7:0]  ADR_CC_IN    = 8'h0c;
    localparam logic [7:0]  ADR_QUAD     = 8'h10;
    localparam logic [7:0]  ADR_STATUS   = 8'h14;
    // ------------------------------------------------------------
    // field layouts
    // ------------------------------------------------------------
    localparam int CFG_FW      = 4;
    localparam int CFG_POL     = 3;
    localparam int CFG_RA_INT  = 16;
    localparam int CFG_RB_INT  = 17;
    localparam int CTL_FW      = 3;
    localparam int CTL_S0      = 0;
    localparam int CTL_S1      = 1;
    localparam int CTL_D       = 2;
    localparam int CIN_INV_IN  = 4;
    localparam int CIN_INV_EN  = 5;
    localparam int ST_CC       = 4;
    localparam int ST_HOPEN    = 5;
    localparam int ST_PSEL     = 8;
    localparam int PSEL_W      = 4;
    localparam int SCAN_LEN    = 2 * PSEL_W;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [31:0] RST_REG    = 32'h0000_0000;
    localparam logic [31:0] RST_LUT    = 32'h9696_6969;
    localparam logic [1:0]  HCLK_HOLD  = 2'h3;
    localparam logic [1:0]  SYNC_FILL  = 2'h2;
    // ------------------------------------------------------------
    // enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        SRC_HARD = 3'h0, SRC_RA = 3'h1, SRC_RB = 3'h3, SRC_INT = 3'h2, SRC_QUAD = 3'h6
    } frc_src_t;
    typedef enum logic [1:0] {
        SCAN_IDLE = 2'h0, SCAN_SHIFT = 2'h1, SCAN_LOAD = 2'h3
    } frc_scan_t;
endpackage

// ==== test/frc_board_model.sv ====
// board clock pins and scan probe tool facing the cell block
`timescale 1ns/10ps
module frc_board_model
(
    // system
    input  wire logic       sys_clk,
    // {top right, top left, bottom right, bottom left, routed b, routed a, hardwired}
    output logic      [6:0] clk_pins,
    output logic            test_reset_pin,
    // scan port
    output logic            scan_tck,
    output logic            scan_tms,
    output logic            scan_tdi
);
    // pin clocks stay well below a quarter of the system clock
    localparam int PHASE = 4;

    initial
    begin
        clk_pins       = 7'h00;
        test_reset_pin = 1'b1;
        scan_tck       = 1'b0;
        scan_tms       = 1'b0;
        scan_tdi       = 1'b0;
    end

    // ------------------------------------------------------------
    // clock pins: stand still unless a task moves them
    // ------------------------------------------------------------
    task automatic set_level(input logic [6:0] which, input logic val);
        @(posedge sys_clk);
        clk_pins <= val ? (clk_pins | which) : (clk_pins & ~which);
        repeat (PHASE) @(posedge sys_clk);
    endtask

    // board grounds the test reset pin, or lets it stand high
    task automatic set_test_reset(input logic val);
        @(posedge sys_clk);
        test_reset_pin <= val;
    endtask

    task automatic pulse(input logic [6:0] which, input int n);
        repeat (n)
        begin
            set_level(which, 1'b1);
            set_level(which, 1'b0);
        end
    endtask

    // ------------------------------------------------------------
    // scan: shift eight select bits, then one load pulse
    // ------------------------------------------------------------
    task automatic tck_pulse;
        @(posedge sys_clk);
        scan_tck <= 1'b1;
        repeat (PHASE) @(posedge sys_clk);
        scan_tck <= 1'b0;
        repeat (PHASE) @(posedge sys_clk);
    endtask

    task automatic load_select(input logic [7:0] sel);
        @(posedge sys_clk);
        scan_tms <= 1'b1;
        for (int i = 7; i >= 0; i--)
        begin
            scan_tdi <= sel[i];
            tck_pulse();
        end
        scan_tms <= 1'b0;
        tck_pulse();
        // data line outside a frame carries no stale value
        scan_tdi <= ~sel[0];
    endtask
endmodule // frc_board_model

// ==== test/frc_cell_clocking_tb.sv ====
// self-checking bench for the register cell and clock network block
`timescale 1ns/10ps
module frc_cell_clocking_tb;
    import frc_pkg::*;
    localparam logic [6:0] P_HW  = 7'h01;
    localparam logic [6:0] P_RA  = 7'h02;
    localparam logic [6:0] P_RB  = 7'h04;
    localparam logic [6:0] P_QBL = 7'h08;
    localparam logic [6:0] P_QTR = 7'h40;
    typedef struct packed
    {
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
        logic [7:0]  radr;
        logic [31:0] mask;
        logic [31:0] exp;
    } frc_row_t;

    logic        SYS_CLK     = 1'b0;
    logic        RST_B       = 1'b0;
    logic        WB_CYC_I    = 1'b0;
    logic        WB_STB_I    = 1'b0;
    logic        WB_WE_I     = 1'b0;
    logic [7:0]  WB_ADR_I    = 8'h00;
    logic [3:0]  WB_SEL_I    = 4'h0;
    logic [31:0] WB_DAT_I    = 32'h0;
    logic [3:0]  CELL_CLEAR  = 4'h0;
    logic [3:0]  CELL_PRESET = 4'h0;
    logic [31:0] WB_DAT_O;
    logic        WB_ACK_O;
    logic [3:0]  CELL_Q;
    logic [6:0]  clk_pins;
    logic        test_reset_pin;
    logic        scan_tck;
    logic        scan_tms;
    logic        scan_tdi;
    logic        SCAN_TDO;
    logic        PROBE_OUT_A;
    logic        PROBE_OUT_B;
    logic [31:0] rd;
    int          bad_count   = 0;
    int          checks      = 0;
    int          cycles      = 0;
    frc_row_t    rows [12];

    always #10 SYS_CLK = ~SYS_CLK;

    frc_cell_clocking #(.NUM_CELLS(4), .TRST_RESERVED(1'b1)) frc_cell_clocking_inst
    (
        .SYS_CLK(SYS_CLK), .RST_B(RST_B),
        .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I),
        .WB_ADR_I(WB_ADR_I), .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I),
        .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
        .HARDWIRED_CLOCK(clk_pins[0]), .ROUTED_CLOCK_A(clk_pins[1]),
        .ROUTED_CLOCK_B(clk_pins[2]), .QUADRANT_CLOCK_BOTTOM_LEFT(clk_pins[3]),
        .QUADRANT_CLOCK_BOTTOM_RIGHT(clk_pins[4]), .QUADRANT_CLOCK_TOP_LEFT(clk_pins[5]),
        .QUADRANT_CLOCK_TOP_RIGHT(clk_pins[6]), .TEST_RESET_PIN(test_reset_pin),
        .CELL_CLEAR(CELL_CLEAR), .CELL_PRESET(CELL_PRESET), .CELL_Q(CELL_Q),
        .SCAN_TCK(scan_tck), .SCAN_TMS(scan_tms), .SCAN_TDI(scan_tdi),
        .SCAN_TDO(SCAN_TDO), .PROBE_OUT_A(PROBE_OUT_A), .PROBE_OUT_B(PROBE_OUT_B)
    );

    frc_board_model frc_board_model_inst
    (
        .sys_clk(SYS_CLK), .clk_pins(clk_pins), .test_reset_pin(test_reset_pin),
        .scan_tck(scan_tck), .scan_tms(scan_tms), .scan_tdi(scan_tdi)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want)
        begin
            bad_count++;
            $display("ERROR at %0t: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic finish_test;
        if (bad_count == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // classic cycle: hold until ack is seen high at a rising edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        int n;
        n = 0;
        @(posedge SYS_CLK);
        WB_CYC_I <= 1'b1;
        WB_STB_I <= 1'b1;
        WB_WE_I  <= we;
        WB_ADR_I <= adr;
        WB_SEL_I <= sel;
        WB_DAT_I <= dat;
        do
        begin
            @(posedge SYS_CLK);
            n++;
        end
        while (WB_ACK_O !== 1'b1 && n < 50);
        if (n >= 50)
        begin
            bad_count++;
            $display("ERROR at %0t: bus not acknowledged", $time);
        end
        rd = WB_DAT_O;
        WB_CYC_I <= 1'b0;
        WB_STB_I <= 1'b0;
        WB_WE_I  <= 1'b0;
    endtask

    always @(posedge SYS_CLK)
    begin
        cycles <= cycles + 1;
        if (cycles == 30000)
        begin
            bad_count++;
            finish_test();
        end
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial
    begin
        rows[0]  = '{ADR_CELL_CFG, 4'hf, 32'h0003_b6a9, ADR_CELL_CFG, '1, 32'h0003_b6a9};
        rows[1]  = '{ADR_CELL_CTL, 4'hf, 32'h0000_0fff, ADR_CELL_CTL, '1, 32'h0000_0fff};
        rows[2]  = '{ADR_QUAD, 4'hf, 32'h0000_00e4, ADR_QUAD, '1, 32'h0000_00e4};
        rows[3]  = '{ADR_LUT, 4'hf, 32'h0001_0002, ADR_LUT, '1, 32'h0001_0002};
        rows[4]  = '{ADR_CC_IN, 4'hf, 32'h0000_0001, ADR_CC_IN, '1, 32'h0000_0001};
        rows[5]  = '{ADR_CC_IN, 4'hf, 32'h0000_0000, ADR_STATUS, 32'h10, 32'h00};
        rows[6]  = '{ADR_CC_IN, 4'hf, 32'h0000_0001, ADR_STATUS, 32'h10, 32'h10};
        rows[7]  = '{ADR_CC_IN, 4'hf, 32'h0000_0020, ADR_STATUS, 32'h10, 32'h10};
        rows[8]  = '{ADR_CC_IN, 4'hf, 32'h0000_0030, ADR_STATUS, 32'h10, 32'h00};
        rows[9]  = '{ADR_STATUS, 4'hf, 32'hffff_ffff, ADR_STATUS, 32'hff00, 32'h0};
        rows[10] = '{8'h18, 4'hf, 32'hffff_ffff, 8'h18, '1, 32'h0};
        rows[11] = '{ADR_LUT, 4'h2, 32'hffff_ffff, ADR_LUT, '1, 32'h0001_ff02};
        repeat (3) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        foreach (rows[i])
        begin
            wb(1'b1, rows[i].adr, rows[i].sel, rows[i].dat);
            wb(1'b0, rows[i].radr, 4'hf, 32'h0);
            check(rd & rows[i].mask, rows[i].exp);
        end
        // second reset in mid-run, then reset values
        RST_B <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        for (int a = 0; a < 6; a++)
        begin
            wb(1'b0, 8'(a * 4), 4'hf, 32'h0);
            check(rd, (a == 2) ? RST_LUT : ((a == 5) ? {27'h0, RST_LUT[0], 4'h0} : RST_REG));
        end
        // hardwired, routed a falling, routed b, quadrant sources
        wb(1'b1, ADR_CELL_CFG, 4'hf, 32'h0000_6390);
        wb(1'b1, ADR_CELL_CTL, 4'hf, 32'h0000_0b6d);
        frc_board_model_inst.pulse(P_HW, 2);
        wb(1'b0, ADR_STATUS, 4'hf, 32'h0);
        check(rd & 32'h20, 32'h0);
        frc_board_model_inst.pulse(P_HW, 1);
        check({28'h0, CELL_Q}, 32'h0);
        wb(1'b0, ADR_STATUS, 4'hf, 32'h0);
        check(rd & 32'h20, 32'h20);
        frc_board_model_inst.pulse(P_HW, 1);
        check({28'h0, CELL_Q}, 32'h1);
        wb(1'b1, ADR_CELL_CTL, 4'hf, 32'h0000_0b68);
        frc_board_model_inst.pulse(P_HW, 1);
        check({28'h0, CELL_Q}, 32'h1);
        wb(1'b1, ADR_CELL_CTL, 4'hf, 32'h0000_0b6a);
        frc_board_model_inst.pulse(P_HW, 1);
        check({28'h0, CELL_Q}, 32'h0);
        frc_board_model_inst.set_level(P_RA, 1'b1);
        check({28'h0, CELL_Q}, 32'h0);
        frc_board_model_inst.set_level(P_RA, 1'b0);
        check({28'h0, CELL_Q}, 32'h2);
        frc_board_model_inst.pulse(P_RB, 1);
        check({28'h0, CELL_Q}, 32'h6);
        frc_board_model_inst.pulse(P_QTR, 1);
        check({28'h0, CELL_Q}, 32'h6);
        frc_board_model_inst.pulse(P_QBL, 1);
        check({28'h0, CELL_Q}, 32'he);
        // clear and preset
        CELL_CLEAR <= 4'h2;
        repeat (5) @(posedge SYS_CLK);
        check({28'h0, CELL_Q}, 32'hc);
        CELL_CLEAR  <= 4'h1;
        CELL_PRESET <= 4'h1;
        repeat (5) @(posedge SYS_CLK);
        check({28'h0, CELL_Q}, 32'hc);
        CELL_CLEAR <= 4'h0;
        repeat (5) @(posedge SYS_CLK);
        check({28'h0, CELL_Q}, 32'hd);
        CELL_PRESET <= 4'h0;
        // probes: a on cell 0, b on routed b
        frc_board_model_inst.load_select(8'h70);
        repeat (8) @(posedge SYS_CLK);
        check({30'h0, PROBE_OUT_B, PROBE_OUT_A}, 32'h1);
        wb(1'b0, ADR_STATUS, 4'hf, 32'h0);
        check(rd & 32'hff00, 32'h7000);
        frc_board_model_inst.set_level(P_RB, 1'b1);
        repeat (4) @(posedge SYS_CLK);
        check({30'h0, PROBE_OUT_B, PROBE_OUT_A}, 32'h3);
        frc_board_model_inst.set_level(P_RB, 1'b0);
        // internal logic as cell source and as routed a source
        wb(1'b1, ADR_LUT, 4'hf, 32'h0000_0002);
        wb(1'b1, ADR_CELL_CFG, 4'hf, 32'h0001_6290);
        wb(1'b1, ADR_CELL_CTL, 4'hf, 32'h0000_0068);
        wb(1'b1, ADR_CC_IN, 4'hf, 32'h0000_0001);
        repeat (6) @(posedge SYS_CLK);
        check({28'h0, CELL_Q}, 32'h9);
        wb(1'b1, ADR_CC_IN, 4'hf, 32'h0000_0000);
        repeat (6) @(posedge SYS_CLK);
        check({28'h0, CELL_Q}, 32'hb);
        // grounded test reset: hardwired clock acts from its first cycle
        frc_board_model_inst.set_test_reset(1'b0);
        RST_B <= 1'b0;
        repeat (3) @(posedge SYS_CLK);
        RST_B <= 1'b1;
        wb(1'b1, ADR_CELL_CTL, 4'hf, 32'h0000_0005);
        frc_board_model_inst.pulse(P_HW, 1);
        check({28'h0, CELL_Q}, 32'h1);
        finish_test();
    end
endmodule // frc_cell_clocking_tb
